// >>> sesu_pkg.sv
package sesu_pkg;
  // Event bit positions, shared by latch and enable mask
  localparam int BIT_PON = 7;
  localparam int BIT_CME = 5;
  localparam int BIT_EXE = 4;
  localparam int BIT_DDE = 3;
  localparam int BIT_QUE = 2;
  localparam int BIT_OPC = 0;
  // Bits 6 and 1 are unused and read zero
  localparam logic [7:0] EVT_USED = 8'hBD;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_ONE = 8'h31;
  localparam int NUM_MAX = 3;
  localparam int IDN_LEN = 21;
  localparam int TRAN_LEN = 9;
  localparam int ACQ_LEN = 7;
  // Name codes of the trigger alias argument
  localparam logic [1:0] NAME_TRAN = 2'h1;
  localparam logic [1:0] NAME_ACQ = 2'h2;

  typedef enum logic [3:0] {
    OP_CLS, OP_ESE_W, OP_ESE_Q, OP_ESR_Q, OP_IDN_Q, OP_OPC, OP_OPC_Q,
    OP_OPT_Q, OP_PSC_W, OP_PSC_Q, OP_SRE_W, OP_SRE_Q, OP_DEF_W, OP_DEF_Q
  } op_t;

  // Decoded command from the parser
  typedef struct packed {
    logic valid;
    op_t op;
    logic [7:0] arg;   // Value, or {name, seq} for alias commands
    logic after_nl;    // Command directly follows a newline terminator
  } cmd_t;

  // One response character
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } resp_t;

  // Nonvolatile write request
  typedef struct packed {
    logic valid;
    logic psc;
    logic [7:0] event_enable_mask;
    logic [7:0] sre;
  } nv_t;

  // Text that a response streams from
  typedef enum logic [1:0] {TXT_NUM, TXT_IDN, TXT_TRAN, TXT_ACQ} txt_t;
endpackage : sesu_pkg

// >>> standard_event_status_unit.sv
`timescale 1ns/1ps
// Function
// - Clear-status zeroes event, operation, questionable latches
// - Clear-status clears status summary, error queue
// - After newline, clear-status also flushes output queue
// - Enabled events OR into event summary bit
// - Shared layout; bits 6 and 1 zero
// - Mask query returns stored mask unchanged
// - Latch read returns value and clears it
// - Identification gives four comma-separated fields
// - Completion bit waits for all pending work
// - Completion command does not stall commands
// - Completion query stalls, then answers 1
// - Output commands overlap; others finish first
// - Option query answers 0 with none fitted
// - Power-on clear flag set zeroes both masks
// - Flag clear keeps masks nonvolatile; writes saved
// - Flag query answers 0 or 1
// - Alias accepts only fixed name per sequence
module standard_event_status_unit #(
  parameter int OPT_CODE = 0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Command port
  input wire sesu_pkg::cmd_t i_cmd,
  output logic o_cmd_ready,
  // Event sources, one-cycle pulses on bits 5..2
  input wire logic [7:0] i_evt,
  // Overlapped operations or triggered actions still running
  input wire logic i_ops_busy,
  // Stored masks and flag from nonvolatile storage
  input wire logic i_nv_psc,
  input wire logic [7:0] i_nv_ese,
  input wire logic [7:0] i_nv_sre,
  // Response characters into the output queue
  output sesu_pkg::resp_t o_resp,
  // Status outputs
  output logic o_esb,
  output logic [7:0] o_sre,
  output logic o_clr_status,
  output logic o_flush_out,
  output sesu_pkg::nv_t o_nv_wr
);
  import sesu_pkg::*;

  typedef enum {S_POWER, S_IDLE, S_SEND, S_WAIT} state_t;

  // Option code answers as a single digit
  if (OPT_CODE < 0 || OPT_CODE > 9) begin : g_bad_opt
    $error("OPT_CODE must be one digit");
  end

  // Arbitrary identity text, not any real maker or part
  localparam logic [8*(IDN_LEN+1)-1:0] ID_TEXT = "MAKER,PS100A,0,A.01.00";
  localparam logic [8*TRAN_LEN-1:0] TRAN_TEXT = "TRANSIENT";
  localparam logic [8*ACQ_LEN-1:0] ACQ_TEXT = "ACQUIRE";

  // Character i of a fixed text; texts left-aligned so a shift keeps selects in range
  function automatic logic [7:0] text_char(input txt_t sel, input logic [4:0] i);
    logic [8*(IDN_LEN+1)-1:0] t;
    logic [8*(IDN_LEN+1)-1:0] sh;
    int n;
    t = '0;
    sh = '0;
    n = 0;
    case (sel)
      TXT_IDN: begin
        t = ID_TEXT;
        n = IDN_LEN + 1;
      end
      TXT_TRAN: begin
        t = {TRAN_TEXT, {(8*(IDN_LEN+1-TRAN_LEN)){1'b0}}};
        n = TRAN_LEN;
      end
      TXT_ACQ: begin
        t = {ACQ_TEXT, {(8*(IDN_LEN+1-ACQ_LEN)){1'b0}}};
        n = ACQ_LEN;
      end
      default: ;
    endcase
    sh = t << {i, 3'b000};
    text_char = (int'(i) < n) ? sh[8*(IDN_LEN+1)-1 -: 8] : CHR_ZERO;
  endfunction : text_char

  logic [7:0] esr_r, esr_nxt, ese_r, ese_nxt, sre_r, sre_nxt;
  logic psc_r, psc_nxt, opc_pend_r, opc_pend_nxt;
  logic esb_r, esb_nxt, ready_r, ready_nxt;
  logic clr_r, clr_nxt, flush_r, flush_nxt;
  state_t state_r, state_nxt;
  txt_t txt_r, txt_nxt;
  logic [4:0] idx_r, idx_nxt, len_r, len_nxt;
  logic [7:0] num_r [NUM_MAX];
  logic [7:0] num_nxt [NUM_MAX];
  resp_t resp_r, resp_nxt;
  nv_t nv_r, nv_nxt;
  logic take, esr_read;

  // Loads a decimal number as up to three characters
  task automatic load_num(input logic [7:0] v);
    num_nxt[0] = (v >= 8'd100) ? CHR_ZERO + v / 8'd100 :
                 (v >= 8'd10) ? CHR_ZERO + v / 8'd10 : CHR_ZERO + v;
    num_nxt[1] = (v >= 8'd100) ? CHR_ZERO + (v / 8'd10) % 8'd10 : CHR_ZERO + v % 8'd10;
    num_nxt[2] = CHR_ZERO + v % 8'd10;
    len_nxt = (v >= 8'd100) ? 5'd3 : (v >= 8'd10) ? 5'd2 : 5'd1;
    txt_nxt = TXT_NUM;
    state_nxt = S_SEND;
  endtask : load_num

  assign take = i_cmd.valid && ready_r;
  assign esr_read = take && i_cmd.op == OP_ESR_Q;

  // Command handling and response sequencing
  always_comb begin
    state_nxt = state_r;
    txt_nxt = txt_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    num_nxt = num_r;
    ese_nxt = ese_r;
    sre_nxt = sre_r;
    psc_nxt = psc_r;
    opc_pend_nxt = opc_pend_r;
    clr_nxt = 1'b0;
    flush_nxt = 1'b0;
    resp_nxt = '0;
    nv_nxt = '0;
    nv_nxt.psc = psc_r;
    nv_nxt.event_enable_mask = ese_r;
    nv_nxt.sre = sre_r;
    // Pending completion retires now; a new completion command below still wins
    if (opc_pend_r && !i_ops_busy) begin
      opc_pend_nxt = 1'b0;
    end
    case (state_r)
      // First cycle after reset: restore or zero the masks
      S_POWER: begin
        psc_nxt = i_nv_psc;
        ese_nxt = i_nv_psc ? MASK_RST : (i_nv_ese & EVT_USED);
        sre_nxt = i_nv_psc ? MASK_RST : i_nv_sre;
        state_nxt = S_IDLE;
      end
      S_IDLE: begin
        // Writes, clear-status and completion finish here in one cycle; queries go on to S_SEND or S_WAIT
        if (take) begin
          case (i_cmd.op)
            OP_CLS: begin
              clr_nxt = 1'b1;
              flush_nxt = i_cmd.after_nl;
              opc_pend_nxt = 1'b0;
            end
            OP_ESE_W: begin
              ese_nxt = i_cmd.arg & EVT_USED;
              nv_nxt.valid = !psc_r;
              nv_nxt.event_enable_mask = i_cmd.arg & EVT_USED;
            end
            OP_SRE_W: begin
              sre_nxt = i_cmd.arg;
              nv_nxt.valid = !psc_r;
              nv_nxt.sre = i_cmd.arg;
            end
            OP_PSC_W: begin
              psc_nxt = i_cmd.arg[0];
              nv_nxt.valid = 1'b1;
              nv_nxt.psc = i_cmd.arg[0];
            end
            OP_ESE_Q: load_num(ese_r);
            OP_SRE_Q: load_num(sre_r);
            OP_ESR_Q: load_num(esr_r);
            OP_PSC_Q: load_num({7'd0, psc_r});
            OP_OPT_Q: load_num(8'(OPT_CODE));
            OP_OPC: opc_pend_nxt = 1'b1;
            OP_OPC_Q: state_nxt = S_WAIT;
            OP_IDN_Q: begin
              txt_nxt = TXT_IDN;
              len_nxt = 5'(IDN_LEN + 1);
              state_nxt = S_SEND;
            end
            OP_DEF_W: ; // Names fixed per sequence; other pairings ignored
            OP_DEF_Q: begin
              txt_nxt = i_cmd.arg[0] ? TXT_ACQ : TXT_TRAN;
              len_nxt = i_cmd.arg[0] ? 5'(ACQ_LEN) : 5'(TRAN_LEN);
              state_nxt = S_SEND;
            end
            default: ;
          endcase
          idx_nxt = '0;
        end
      end
      // Completion query holds off all later commands
      S_WAIT: begin
        if (!i_ops_busy) begin
          num_nxt[0] = CHR_ONE;
          len_nxt = 5'd1;
          txt_nxt = TXT_NUM;
          idx_nxt = '0;
          state_nxt = S_SEND;
        end
      end
      S_SEND: begin
        resp_nxt.valid = 1'b1;
        resp_nxt.data = (txt_r == TXT_NUM) ? num_r[idx_r[1:0]] : text_char(txt_r, idx_r);
        resp_nxt.last = (idx_r == len_r - 5'd1);
        idx_nxt = idx_r + 5'd1;
        if (resp_nxt.last) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    ready_nxt = (state_nxt == S_IDLE);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= S_POWER;
      txt_r <= TXT_NUM;
      idx_r <= '0;
      len_r <= '0;
      for (int k = 0; k < NUM_MAX; k++) num_r[k] <= CHR_ZERO;
      ese_r <= MASK_RST;
      sre_r <= MASK_RST;
      psc_r <= 1'b1;
      opc_pend_r <= 1'b0;
      clr_r <= 1'b0;
      flush_r <= 1'b0;
      resp_r <= '0;
      nv_r <= '0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      txt_r <= txt_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      num_r <= num_nxt;
      ese_r <= ese_nxt;
      sre_r <= sre_nxt;
      psc_r <= psc_nxt;
      opc_pend_r <= opc_pend_nxt;
      clr_r <= clr_nxt;
      flush_r <= flush_nxt;
      resp_r <= resp_nxt;
      nv_r <= nv_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Event latch: new events beat a read or clear in the same cycle
  always_comb begin
    esr_nxt = esr_r;
    if (esr_read || (take && i_cmd.op == OP_CLS)) begin
      esr_nxt = '0;
    end
    esr_nxt = esr_nxt | (i_evt & EVT_USED);
    if (state_r == S_POWER) begin
      esr_nxt[BIT_PON] = 1'b1;
    end
    if (opc_pend_r && !i_ops_busy) begin
      esr_nxt[BIT_OPC] = 1'b1;
    end
    esb_nxt = |(esr_nxt & ese_nxt);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      esr_r <= '0;
      esb_r <= 1'b0;
    end else begin
      esr_r <= esr_nxt;
      esb_r <= esb_nxt;
    end
  end

  assign o_cmd_ready = ready_r;
  assign o_resp = resp_r;
  assign o_esb = esb_r;
  assign o_sre = sre_r;
  assign o_clr_status = clr_r;
  assign o_flush_out = flush_r;
  assign o_nv_wr = nv_r;

  // Summary follows the enabled latch bits
  esb_match_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_esb == |(esr_r & ese_r)) else $error("summary bit mismatch");
  unused_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (esr_r[6] == 1'b0) && (esr_r[1] == 1'b0) && (ese_r[6] == 1'b0) && (ese_r[1] == 1'b0))
    else $error("unused bit set");
  esr_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    esr_read && (i_evt == 8'h00) && !(opc_pend_r && !i_ops_busy) |=> esr_r == 8'h00)
    else $error("latch not cleared on read");
  cls_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take && i_cmd.op == OP_CLS |=> o_clr_status && (o_flush_out == $past(i_cmd.after_nl)))
    else $error("clear-status pulses wrong");
  latch_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $past(esr_r[5]) && !$past(esr_read) && !$past(take && i_cmd.op == OP_CLS) |-> esr_r[5])
    else $error("event bit lost");
  opc_wait_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_WAIT && i_ops_busy |=> !o_resp.valid && !o_cmd_ready)
    else $error("completion query answered early");
  opc_answer_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_WAIT && !i_ops_busy |=> ##1 o_resp.valid && o_resp.data == 8'h31 && o_resp.last)
    else $error("completion answer wrong");
  opc_nostall_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take && i_cmd.op == OP_OPC |=> o_cmd_ready) else $error("completion stalls");
  nv_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take && (i_cmd.op == OP_PSC_W || (i_cmd.op == OP_ESE_W && !psc_r)) |=> o_nv_wr.valid)
    else $error("missing nonvolatile write");
  psc_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_POWER && i_nv_psc |=> ese_r == 8'h00 && o_sre == 8'h00)
    else $error("masks kept at power-on");
  // Alias query answers the fixed name of the sequence asked for
  alias_name_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take && i_cmd.op == OP_DEF_Q |=> ##1 o_resp.valid && (o_resp.data ==
    ($past(i_cmd.arg[0], 2) ? ACQ_TEXT[8*ACQ_LEN-1 -: 8] : TRAN_TEXT[8*TRAN_LEN-1 -: 8])))
    else $error("alias name wrong");
endmodule : standard_event_status_unit

// >>> ctrl_model.sv
`timescale 1ns/1ps
// Remote controller: one command at a time, replies gathered as text
module ctrl_model import sesu_pkg::*; (
  // Clock
  input wire logic i_core_clk,
  // Command side
  input wire logic i_ready,
  output sesu_pkg::cmd_t o_cmd,
  // Reply side
  input wire sesu_pkg::resp_t i_resp
);
  string rx = "";
  logic rx_done = 1'b0;
  // Commands dropped when the wait limit ran out
  int n_lost = 0;
  initial o_cmd = '0;
  // Reply characters kept in arrival order
  always @(posedge i_core_clk) begin
    if (i_resp.valid === 1'b1) begin
      rx = {rx, string'(i_resp.data)};
      rx_done = i_resp.last;
    end
  end
  // Held until taken; an idle edge first keeps valid from toggling twice
  // Issues only what the bench asks, so no repeated nonvolatile writes
  task automatic send(input op_t op, input logic [7:0] arg, input logic nl);
    int n;
    n = 0;
    @(posedge i_core_clk);
    #1;
    o_cmd <= '{valid: 1'b1, op: op, arg: arg, after_nl: nl};
    while (i_ready !== 1'b1 && n < 300) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    if (i_ready !== 1'b1) n_lost++;
    @(posedge i_core_clk);
    #1;
    o_cmd.valid <= 1'b0;
  endtask : send
endmodule : ctrl_model

// >>> standard_event_status_unit_tb.sv
`timescale 1ns/1ps
module standard_event_status_unit_tb;
  import sesu_pkg::*;
  typedef struct {op_t op; logic [7:0] arg; string exp;} row_t;
  logic core_clk, rst, busy, nv_psc;
  logic [7:0] evt, nv_ese, nv_sre, sre;
  logic ready, esb, clr, flush;
  cmd_t cmd;
  resp_t resp;
  nv_t nv;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int commas;
  string s;
  // Writes carry an empty reply; queries carry the text expected
  row_t rows[] = '{'{OP_ESE_Q, 8'h00, "0"}, '{OP_ESR_Q, 8'h00, "128"},
    '{OP_ESR_Q, 8'h00, "0"}, '{OP_ESE_W, 8'h81, ""}, '{OP_ESE_Q, 8'h00, "129"},
    '{OP_ESE_W, 8'hFF, ""}, '{OP_ESE_Q, 8'h00, "189"}, '{OP_SRE_W, 8'h14, ""},
    '{OP_SRE_Q, 8'h00, "20"}, '{OP_PSC_W, 8'h00, ""}, '{OP_PSC_Q, 8'h00, "0"},
    '{OP_PSC_W, 8'h01, ""}, '{OP_PSC_Q, 8'h00, "1"}, '{OP_OPT_Q, 8'h00, "0"}};

  standard_event_status_unit #(.OPT_CODE(0)) i_dut (.i_core_clk(core_clk), .i_rst(rst),
    .i_cmd(cmd), .o_cmd_ready(ready), .i_evt(evt), .i_ops_busy(busy), .i_nv_psc(nv_psc),
    .i_nv_ese(nv_ese), .i_nv_sre(nv_sre), .o_resp(resp), .o_esb(esb), .o_sre(sre),
    .o_clr_status(clr), .o_flush_out(flush), .o_nv_wr(nv));
  ctrl_model ctl (.i_core_clk(core_clk), .i_ready(ready), .o_cmd(cmd), .i_resp(resp));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, well above the whole sequence
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    // Commands the model gave up on count as mismatches
    n_errors += ctl.n_lost;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [63:0] pk(input string t);
    pk = '0;
    foreach (t[k]) pk = {pk[55:0], t[k]};
  endfunction : pk

  // Query and wait, bounded, for the final character
  task automatic ask(input op_t op, input logic [7:0] arg, output string r);
    ctl.rx = "";
    ctl.rx_done = 1'b0;
    ctl.send(op, arg, 1'b0);
    repeat (60) if (ctl.rx_done !== 1'b1) @(posedge core_clk);
    // A reply that never ends counts as a mismatch
    if (ctl.rx_done !== 1'b1) n_errors++;
    r = ctl.rx;
    // Leave the edge so later stimulus never races the design
    #1;
  endtask : ask

  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
  endtask : do_reset

  // One-cycle event pulse, then time for latch and summary to settle
  task automatic pulse(input logic [7:0] v);
    evt = v;
    @(posedge core_clk);
    #1;
    evt = 8'h00;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : pulse

  initial begin
    rst = 1'b1;
    busy = 1'b0;
    evt = 8'h00;
    nv_psc = 1'b1;
    nv_ese = 8'hFF;
    nv_sre = 8'hFF;
    #1;
    do_reset();
    ask(OP_OPT_Q, 8'h00, s);
    check(pk(s), pk("0"));
    check(sre, 8'h00);
    repeat (5) @(posedge core_clk);
    #1;
    foreach (rows[k]) begin
      if (rows[k].exp == "") ctl.send(rows[k].op, rows[k].arg, 1'b0);
      else begin
        ask(rows[k].op, rows[k].arg, s);
        check(pk(s), pk(rows[k].exp));
      end
    end
    // Latched events, summary, unused bit 6 ignored
    ctl.send(OP_ESE_W, 8'h20, 1'b0);
    check(nv.valid, 1'b0);
    pulse(8'h60);
    check(esb, 1'b1);
    ask(OP_ESR_Q, 8'h00, s);
    check(pk(s), pk("32"));
    repeat (2) @(posedge core_clk);
    #1;
    check(esb, 1'b0);
    // Clear-status with and without a preceding terminator
    pulse(8'h30);
    ctl.send(OP_CLS, 8'h00, 1'b1);
    check({clr, flush}, 2'b11);
    ask(OP_ESR_Q, 8'h00, s);
    check(pk(s), pk("0"));
    ctl.send(OP_CLS, 8'h00, 1'b0);
    check({clr, flush}, 2'b10);
    // Completion command while overlapped work runs
    ctl.send(OP_ESE_W, 8'h01, 1'b0);
    busy = 1'b1;
    ctl.send(OP_OPC, 8'h00, 1'b0);
    check(ready, 1'b1);
    ask(OP_ESE_Q, 8'h00, s);
    check(pk(s), pk("1"));
    check(esb, 1'b0);
    busy = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check(esb, 1'b1);
    ask(OP_ESR_Q, 8'h00, s);
    check(pk(s), pk("1"));
    // Completion query holds its answer until work is done
    busy = 1'b1;
    fork
      ask(OP_OPC_Q, 8'h00, s);
      begin
        repeat (12) @(posedge core_clk);
        #1;
        check(pk(ctl.rx), 64'h0000_0000_0000_0000);
        busy = 1'b0;
      end
    join
    check(pk(s), pk("1"));
    // Nonvolatile writes follow the flag
    ctl.send(OP_PSC_W, 8'h00, 1'b0);
    check({nv.valid, nv.psc}, 2'b10);
    ctl.send(OP_ESE_W, 8'h05, 1'b0);
    check({nv.valid, nv.event_enable_mask}, 9'h105);
    ctl.send(OP_SRE_W, 8'h2A, 1'b0);
    check({nv.valid, nv.sre}, 9'h12A);
    // Alias names: wrong pairings leave the fixed name in place
    ctl.send(OP_DEF_W, 8'h04, 1'b0);
    ctl.send(OP_DEF_W, 8'h03, 1'b0);
    ask(OP_DEF_Q, 8'h00, s);
    check(s.len(), TRAN_LEN);
    check(pk(s), pk("TRANSIENT"));
    ask(OP_DEF_Q, 8'h01, s);
    check(s.len(), ACQ_LEN);
    check(pk(s), pk("ACQUIRE"));
    ask(OP_IDN_Q, 8'h00, s);
    commas = 0;
    foreach (s[k]) if (s[k] == ",") commas++;
    check({s.len(), commas}, {32'd22, 32'd3});
    // Stored masks restored when the flag is clear
    nv_psc = 1'b0;
    nv_ese = 8'h81;
    nv_sre = 8'h14;
    do_reset();
    ask(OP_ESE_Q, 8'h00, s);
    check(pk(s), pk("129"));
    check({sre, esb}, 9'h029);
    conclude();
  end
endmodule : standard_event_status_unit_tb
